// ==== hw/lamp_driver.sv ====
// one chassis lamp driven from its two-bit control code
`timescale 1ns/1ns
`include "slot_control_map.svh"
module lamp_driver
	import slot_control_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire lamp_code_t code_in,
	input  wire logic       present_in,
	input  wire logic       blink_tick_in,
	output logic            lamp_on_out
);
	blink_phase_t phase_q;
	blink_phase_t phase_d;
	logic         lamp_d;

	// blink phase flips on every half-period tick
	always_comb begin
		case (phase_q)
			PHASE_LIT:  phase_d = blink_tick_in ? PHASE_DARK : PHASE_LIT;
			PHASE_DARK: phase_d = blink_tick_in ? PHASE_LIT : PHASE_DARK;
			default:    phase_d = PHASE_LIT;
		endcase
	end

	// reserved code 00 leaves the lamp dark rather than guessing a state
	assign lamp_d = present_in &
		((code_in == `LAMP_ON) |
		 ((code_in == `LAMP_BLINK) & (phase_q == PHASE_LIT)));

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_q     <= PHASE_LIT;
			lamp_on_out <= 1'b0;
		end else begin
			phase_q     <= phase_d;
			lamp_on_out <= lamp_d;
		end
	end
endmodule

// ==== hw/pcie_slot_control_register.sv ====
// hot-plug slot control register of a root port, with its slot-side drives
`timescale 1ns/1ns
`include "slot_control_map.svh"
module pcie_slot_control_register
	import slot_control_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_MS * 1000000 / `CLK_PERIOD_NS
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// configuration access, dword address with byte enables
	input  wire logic [11:0] cfg_addr_in,
	input  wire logic        cfg_wr_in,
	input  wire logic        cfg_rd_in,
	input  wire logic [3:0]  cfg_be_in,
	input  wire cfg_word_t   cfg_wdata_in,
	output cfg_word_t        cfg_rdata_out,
	output logic             cfg_rvalid_out,
	// slot capability straps
	input  wire logic        cap_link_active_in,
	input  wire logic        cap_interlock_in,
	input  wire logic        cap_power_ctrl_in,
	input  wire logic        cap_power_lamp_in,
	input  wire logic        cap_attn_lamp_in,
	input  wire logic        cap_hotplug_in,
	// slot events
	input  wire logic        link_active_in,
	input  wire logic        hotplug_event_in,
	input  wire logic        power_fault_in,
	// slot-side drives
	output logic             slot_power_on_out,
	output logic             interlock_engaged_out,
	output logic             power_lamp_out,
	output logic             attention_lamp_out,
	output logic             link_change_notify_out,
	output logic             hotplug_irq_out
);
	localparam logic [11:0] SLOT_OFF       = `SLOT_CTL_OFFSET;
	localparam slot_ctl_t   CTL_RESET      = `SLOT_CTL_RESET;
	localparam logic [25:0] BLINK_LAST     = 26'(BLINK_HALF_CYCLES - 1);
	localparam int          LINK_NOTIFY_B  = `LINK_NOTIFY_BIT;
	localparam int          INTERLOCK_B    = `INTERLOCK_BIT;
	localparam int          POWER_CMD_B    = `POWER_CMD_BIT;
	localparam int          PWR_LAMP_B     = `PWR_LAMP_LSB;
	localparam int          ATTN_LAMP_B    = `ATTN_LAMP_LSB;
	localparam int          IRQ_EN_B       = `IRQ_EN_BIT;

	// one dword holds this register in its low half and the slot status above it
	function automatic logic dword_hit(input logic [11:0] addr);
		dword_hit = (addr[11:2] == SLOT_OFF[11:2]);
	endfunction

	// stored fields
	logic        link_notify_q;
	logic        power_cmd_q;
	lamp_code_t  power_lamp_q;
	lamp_code_t  attn_lamp_q;
	logic        irq_en_q;
	logic        interlock_q;
	logic        link_prev_q;
	logic [25:0] blink_cnt_q;
	logic        blink_tick_q;

	logic        link_notify_d;
	logic        power_cmd_d;
	lamp_code_t  power_lamp_d;
	lamp_code_t  attn_lamp_d;
	logic        irq_en_d;
	logic        interlock_d;
	logic [25:0] blink_cnt_d;
	logic        blink_tick_d;

	// access decode
	wire         wr_hit;
	wire         rd_hit;
	wire         wr_lo;
	wire         wr_hi;
	wire         wr_link_notify;
	wire         wr_power_cmd;
	wire         wr_power_lamp;
	wire         wr_attn_lamp;
	wire         wr_irq_en;
	wire         toggle_req;
	wire         link_changed;
	wire         link_notify_d_ev;
	wire         irq_d;
	wire         power_on_d;
	wire         blink_wrap;
	slot_ctl_t   ctl_view;
	cfg_word_t   rdata_d;

	assign wr_hit = cfg_wr_in & dword_hit(cfg_addr_in);
	assign rd_hit = cfg_rd_in & dword_hit(cfg_addr_in);
	assign wr_lo  = wr_hit & cfg_be_in[0];
	assign wr_hi  = wr_hit & cfg_be_in[1];

	// per-field write strobes; a missing capability turns its field read-only
	assign wr_link_notify = wr_hi & cap_link_active_in;
	assign wr_power_cmd   = wr_hi & cap_power_ctrl_in;
	assign wr_power_lamp  = wr_hi & cap_power_lamp_in;
	assign wr_attn_lamp   = wr_lo & cap_attn_lamp_in;
	assign wr_irq_en      = wr_lo & cap_hotplug_in;

	// each field takes a write only where its strobe fires, else it holds its value
	assign link_notify_d = wr_link_notify ?
		cfg_wdata_in[LINK_NOTIFY_B] : link_notify_q;
	assign power_cmd_d   = wr_power_cmd ?
		cfg_wdata_in[POWER_CMD_B] : power_cmd_q;
	assign power_lamp_d  = wr_power_lamp ?
		cfg_wdata_in[PWR_LAMP_B +: 2] : power_lamp_q;
	assign attn_lamp_d   = wr_attn_lamp ?
		cfg_wdata_in[ATTN_LAMP_B +: 2] : attn_lamp_q;
	assign irq_en_d      = wr_irq_en ?
		cfg_wdata_in[IRQ_EN_B] : irq_en_q;

	// the toggle bit is a command, never stored; a zero written does nothing
	assign toggle_req  = wr_hi & cap_interlock_in & cfg_wdata_in[INTERLOCK_B];
	assign interlock_d = interlock_q ^ toggle_req;

	// readback is the stored field, so a pending command never hides the last write
	always_comb begin
		ctl_view                      = 16'h0000;
		ctl_view[LINK_NOTIFY_B]       = link_notify_q;
		ctl_view[INTERLOCK_B]         = 1'b0;
		ctl_view[POWER_CMD_B]         = power_cmd_q;
		ctl_view[PWR_LAMP_B +: 2]     = power_lamp_q;
		ctl_view[ATTN_LAMP_B +: 2]    = attn_lamp_q;
		ctl_view[IRQ_EN_B]            = irq_en_q;
	end

	// slot status half of the dword is handled elsewhere and reads zero here
	assign rdata_d = rd_hit ? {16'h0000, ctl_view} : 32'h0000_0000;

	// link-active edges, reported only while enabled
	assign link_changed     = link_active_in ^ link_prev_q;
	assign link_notify_d_ev = link_changed & cap_link_active_in & link_notify_q;

	// master enable gates the enabled link-change event and the unmasked hot-plug event onto the interrupt
	assign irq_d = irq_en_q & cap_hotplug_in &
		(link_notify_d_ev | hotplug_event_in);

	// a fault wins over the command; without a controller the slot stays powered
	assign power_on_d = (~cap_power_ctrl_in | ~power_cmd_q) & ~power_fault_in;

	// shared blink timebase so both lamps blink in step
	assign blink_wrap   = (blink_cnt_q == BLINK_LAST);
	assign blink_cnt_d  = blink_wrap ? 26'h000_0000 : blink_cnt_q + 26'h000_0001;
	assign blink_tick_d = blink_wrap;

	// link-change notification enable
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_notify_q <= CTL_RESET[LINK_NOTIFY_B];
		end else begin
			link_notify_q <= link_notify_d;
		end
	end

	// slot power command, zero meaning on
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_cmd_q <= `POWER_CMD_RESET;
		end else begin
			power_cmd_q <= power_cmd_d;
		end
	end

	// power lamp code
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_lamp_q <= CTL_RESET[PWR_LAMP_B +: 2];
		end else begin
			power_lamp_q <= power_lamp_d;
		end
	end

	// attention lamp code
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			attn_lamp_q <= CTL_RESET[ATTN_LAMP_B +: 2];
		end else begin
			attn_lamp_q <= attn_lamp_d;
		end
	end

	// hot-plug interrupt enable
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_en_q <= CTL_RESET[IRQ_EN_B];
		end else begin
			irq_en_q <= irq_en_d;
		end
	end

	// interlock state, moved only by a toggle command
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interlock_q <= 1'b0;
		end else begin
			interlock_q <= interlock_d;
		end
	end

	// read data, one cycle after the request
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rdata_out <= 32'h0000_0000;
		end else begin
			cfg_rdata_out <= rdata_d;
		end
	end

	// valid follows every read strobe, hit or miss, so a stray read never hangs the host
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rvalid_out <= 1'b0;
		end else begin
			cfg_rvalid_out <= cfg_rd_in;
		end
	end

	// last link level, for edge detection
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_prev_q <= 1'b0;
		end else begin
			link_prev_q <= link_active_in;
		end
	end

	// link-change notification pulse
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_change_notify_out <= 1'b0;
		end else begin
			link_change_notify_out <= link_notify_d_ev;
		end
	end

	// hot-plug interrupt pulse
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hotplug_irq_out <= 1'b0;
		end else begin
			hotplug_irq_out <= irq_d;
		end
	end

	// slot power drive, registered so a glitch on the fault pin never reaches the slot
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_power_on_out <= 1'b0;
		end else begin
			slot_power_on_out <= power_on_d;
		end
	end

	// interlock drive mirrors the stored state
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interlock_engaged_out <= 1'b0;
		end else begin
			interlock_engaged_out <= interlock_d;
		end
	end

	// blink divider; long count kept as a parameter so simulation can shorten it
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			blink_cnt_q <= 26'h000_0000;
		end else begin
			blink_cnt_q <= blink_cnt_d;
		end
	end

	// one-cycle tick at the end of each blink half period
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			blink_tick_q <= 1'b0;
		end else begin
			blink_tick_q <= blink_tick_d;
		end
	end

	// chassis lamps driven straight from their control fields
	lamp_driver u_power_lamp (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.code_in       (power_lamp_q),
		.present_in    (cap_power_lamp_in),
		.blink_tick_in (blink_tick_q),
		.lamp_on_out   (power_lamp_out)
	);

	lamp_driver u_attn_lamp (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.code_in       (attn_lamp_q),
		.present_in    (cap_attn_lamp_in),
		.blink_tick_in (blink_tick_q),
		.lamp_on_out   (attention_lamp_out)
	);
endmodule

// ==== hw/slot_control_map.svh ====
// offsets, field positions, reset values and timing counts of the hot-plug slot control register
`ifndef SLOT_CONTROL_MAP_SVH
`define SLOT_CONTROL_MAP_SVH

`define SLOT_CTL_OFFSET   12'h0B8
`define SLOT_CTL_RESET    16'h01C0

`define LINK_NOTIFY_BIT   12
`define INTERLOCK_BIT     11
`define POWER_CMD_BIT     10
`define PWR_LAMP_LSB      8
`define ATTN_LAMP_LSB     6
`define IRQ_EN_BIT        5

`define LAMP_RSVD         2'h0
`define LAMP_ON           2'h1
`define LAMP_BLINK        2'h2
`define LAMP_OFF          2'h3

`define POWER_CMD_RESET   1'h0
`define BLINK_HALF_MS     500
`define CLK_PERIOD_NS     8

`endif

// ==== hw/slot_control_pkg.sv ====
// types shared by the slot control register and its lamp drivers
package slot_control_pkg;
	typedef logic [1:0]  lamp_code_t;
	typedef logic [15:0] slot_ctl_t;
	typedef logic [31:0] cfg_word_t;
	typedef enum logic {
		PHASE_LIT,
		PHASE_DARK
	} blink_phase_t;
endpackage

// ==== tb/pcie_slot_control_register_tb.sv ====
// self-checking bench of the slot control register
`timescale 1ns/1ns
module pcie_slot_control_register_tb import slot_control_pkg::*;;
	logic        sys_clk_in = 1'h0;
	logic        rst_n_in = 1'h0;
	logic [11:0] cfg_addr_in = 12'h0B8;
	logic        cfg_wr_in = 1'h0;
	logic        cfg_rd_in = 1'h0;
	logic [3:0]  cfg_be_in = 4'h0;
	cfg_word_t   cfg_wdata_in = 32'h0, cfg_rdata_out, rd_v;
	logic        cap_link_active_in = 1'h1, cap_interlock_in = 1'h1, cap_power_ctrl_in = 1'h1;
	logic        cap_power_lamp_in = 1'h1, cap_attn_lamp_in = 1'h1, cap_hotplug_in = 1'h1;
	logic        hotplug_event_in = 1'h0, fault_cmd = 1'h0, p_q;
	logic        cfg_rvalid_out, link_active_in, power_fault_in, slot_power_on_out;
	logic        interlock_engaged_out, power_lamp_out, attention_lamp_out;
	logic        link_change_notify_out, hotplug_irq_out;
	int          miscompares = 0, comparisons = 0, cycles = 0, n_cnt, i_cnt, l_cnt;
	// be, write data, expected readback
	logic [35:0] rows [6] = '{36'h31FFF17E0, 36'h100401740, 36'h201000140,
		36'h302A002A0, 36'h0FFFF02A0, 36'h313201320};
	pcie_slot_control_register #(.BLINK_HALF_CYCLES(8)) DUT (.*);
	slot_partner u_partner (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.slot_power_on_in(slot_power_on_out), .fault_cmd_in(fault_cmd),
		.link_active_out(link_active_in), .power_fault_out(power_fault_in));
	always #4 sys_clk_in = ~sys_clk_in;
	// event counters and a hang limit well above the roughly 140 cycles needed
	always @(posedge sys_clk_in) begin
		cycles++;
		n_cnt += int'(link_change_notify_out === 1'h1);
		i_cnt += int'(hotplug_irq_out === 1'h1);
		l_cnt += int'(power_lamp_out === 1'h1 && p_q === 1'h0);
		p_q <= power_lamp_out;
		if (cycles == 3000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input cfg_word_t seen, input cfg_word_t exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// settling gap after each write keeps commands apart
	task automatic wr(input logic [3:0] be, input logic [15:0] d);
		cfg_be_in = be;
		cfg_wdata_in = {16'h0000, d};
		cfg_wr_in = 1'h1;
		@(negedge sys_clk_in);
		cfg_wr_in = 1'h0;
		repeat (3) @(negedge sys_clk_in);
	endtask
	task automatic rd(input logic [11:0] a);
		cfg_addr_in = a;
		cfg_rd_in = 1'h1;
		@(negedge sys_clk_in);
		cfg_rd_in = 1'h0;
		cfg_addr_in = 12'h0B8;
		chk(cfg_rvalid_out, 1);
		rd_v = cfg_rdata_out;
		@(negedge sys_clk_in);
	endtask
	task automatic pulse();
		hotplug_event_in = 1'h1;
		@(negedge sys_clk_in);
		hotplug_event_in = 1'h0;
		repeat (2) @(negedge sys_clk_in);
	endtask
	initial begin
		repeat (6) @(negedge sys_clk_in);
		rst_n_in = 1'h1;
		repeat (2) @(negedge sys_clk_in);
		chk(power_lamp_out, 1);
		chk(attention_lamp_out, 0);
		rd(12'h0B8);
		chk(rd_v, 32'h01C0);
		rd(12'h0BC);
		chk(rd_v, 0);
		wr(4'h2, 16'h0900);
		chk(interlock_engaged_out, 1);
		rd(12'h0B8);
		chk(rd_v, 32'h01C0);
		wr(4'h2, 16'h0100);
		chk(interlock_engaged_out, 1);
		$display("reset and interlock test done");
		foreach (rows[k]) begin
			wr(rows[k][35:32], rows[k][31:16]);
			rd(12'h0B8);
			chk(rd_v, rows[k][15:0]);
			chk(slot_power_on_out, !rows[k][10]);
			if (rows[k][9:8] != 2'h2)
				chk(power_lamp_out, rows[k][9:8] == 2'h1);
			if (rows[k][7:6] != 2'h2)
				chk(attention_lamp_out, rows[k][7:6] == 2'h1);
		end
		$display("register rows test done");
		// blink half period of 8 cycles gives two or three rises in 36 cycles
		l_cnt = 0;
		wr(4'h3, 16'h12A0);
		repeat (32) @(negedge sys_clk_in);
		chk(l_cnt > 1 && l_cnt < 4, 1);
		n_cnt = 0;
		i_cnt = 0;
		wr(4'h3, 16'h1720);
		wr(4'h3, 16'h1320);
		repeat (8) @(negedge sys_clk_in);
		chk(n_cnt, 2);
		chk(i_cnt, 2);
		pulse();
		chk(i_cnt, 3);
		// power stays commanded on, so only the fault can take it away
		wr(4'h3, 16'h1100);
		pulse();
		fault_cmd = 1'h1;
		repeat (6) @(negedge sys_clk_in);
		chk(slot_power_on_out, 0);
		chk(n_cnt, 3);
		chk(i_cnt, 3);
		$display("event test done");
		fault_cmd = 1'h0;
		rst_n_in = 1'h0;
		{cap_link_active_in, cap_interlock_in, cap_power_ctrl_in} = 3'h0;
		{cap_power_lamp_in, cap_attn_lamp_in, cap_hotplug_in} = 3'h0;
		repeat (6) @(negedge sys_clk_in);
		rst_n_in = 1'h1;
		wr(4'h3, 16'hFFFF);
		rd(12'h0B8);
		chk(rd_v, 32'h01C0);
		chk(slot_power_on_out, 1);
		chk(interlock_engaged_out, 0);
		$display("read-only test done");
		conclude();
	end
endmodule

// ==== tb/slot_ctl_asserts.sv ====
// port-level checker of the hot-plug slot control register
`timescale 1ns/1ns
module slot_ctl_asserts
	import slot_control_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic [11:0] cfg_addr_in,
	input wire logic        cfg_wr_in,
	input wire logic        cfg_rd_in,
	input wire logic [3:0]  cfg_be_in,
	input wire cfg_word_t   cfg_wdata_in,
	input wire cfg_word_t   cfg_rdata_out,
	input wire logic        cfg_rvalid_out,
	input wire logic        cap_link_active_in,
	input wire logic        cap_interlock_in,
	input wire logic        cap_hotplug_in,
	input wire logic        link_active_in,
	input wire logic        hotplug_event_in,
	input wire logic        power_fault_in,
	input wire logic        slot_power_on_out,
	input wire logic        interlock_engaged_out,
	input wire logic        link_change_notify_out,
	input wire logic        hotplug_irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// toggle request only counts when byte 1 of our dword is enabled
	wire tog = cfg_wr_in && cfg_addr_in[11:2] == 10'h02E && cfg_be_in[1] && cfg_wdata_in[11];
	wire tog_ok = tog && cap_interlock_in;
	// register access
	chk_read_answer: assert property (cfg_rd_in |=> cfg_rvalid_out)
		else $error("read not answered");
	chk_toggle_reads_zero: assert property (cfg_rvalid_out |-> !cfg_rdata_out[11])
		else $error("toggle bit read as one");
	chk_reserved_zero: assert property (cfg_rvalid_out |-> cfg_rdata_out[31:13] == 19'h00000 && cfg_rdata_out[4:0] == 5'h00)
		else $error("reserved bits set");
	// interlock
	chk_toggle_flips: assert property (tog_ok |=> interlock_engaged_out != $past(interlock_engaged_out))
		else $error("interlock did not flip");
	chk_toggle_idle: assert property (!tog_ok |=> $stable(interlock_engaged_out))
		else $error("interlock moved");
	// slot side
	chk_fault_power: assert property (power_fault_in |=> !slot_power_on_out)
		else $error("power kept through fault");
	chk_notify_cause: assert property (link_change_notify_out |-> $past(cap_link_active_in) && $past(link_active_in) != $past(link_active_in, 2))
		else $error("notify without link change");
	chk_irq_cause: assert property (hotplug_irq_out |-> $past(cap_hotplug_in) && ($past(hotplug_event_in) || link_change_notify_out))
		else $error("irq without cause");
	cover property (tog_ok);
	cover property (link_change_notify_out);
	cover property (hotplug_irq_out);
endmodule
bind pcie_slot_control_register slot_ctl_asserts u_chk (.*);

// ==== tb/slot_partner.sv ====
// far side: slot power controller with link training and fault injection
`timescale 1ns/1ns
module slot_partner #(
	parameter int unsigned LINK_UP = 4
) (
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	input  wire logic slot_power_on_in,
	input  wire logic fault_cmd_in,
	output logic      link_active_out,
	output logic      power_fault_out
);
	logic [7:0] up_q;
	// link trains a while after power comes and drops at once without it
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			up_q <= 8'h00;
			link_active_out <= 1'h0;
			power_fault_out <= 1'h0;
		end else begin
			power_fault_out <= fault_cmd_in;
			up_q <= !slot_power_on_in ? 8'h00 : up_q + 8'(up_q != LINK_UP[7:0]);
			link_active_out <= slot_power_on_in && up_q == LINK_UP[7:0];
		end
	end
endmodule
